// [hdl/lbseq_pkg.sv]
package lbseq_pkg;

   // Register offsets and fields
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STAT = 12'h004;
   localparam int CTRL_EM_BIT = 0;
   localparam int CTRL_TS_BIT = 1;
   localparam int CTRL_IE_BIT = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int STAT_QUEUE_LSB = 8;
   localparam int STAT_VEC_LSB = 16;

   // Special port and status addresses
   localparam logic [23:0] COP_PORT_CMD = 24'h0000f8;
   localparam logic [23:0] COP_PORT_DATA = 24'h0000fa;
   localparam logic [23:0] HALT_ADDR = 24'h000002;
   localparam logic [23:0] SHUT_ADDR = 24'h000000;
   localparam logic [23:0] PF_RESET_ADDR = 24'h000000;

   // Status codes, {s1_n, s0_n}
   localparam logic [1:0] CODE_IDLE = 2'h3;
   localparam logic [1:0] CODE_READ = 2'h2;
   localparam logic [1:0] CODE_WRITE = 2'h1;
   localparam logic [1:0] CODE_ACK = 2'h0;

   // Counts in processor clocks; queue size and minimum free space in bytes
   localparam logic [1:0] INTERRUPT_ACKNOWLEDGE_CYCLE_GAP = 2'h3;
   localparam logic [1:0] INTERRUPT_ACKNOWLEDGE_CYCLE_COOL = 2'h3;
   localparam logic [1:0] PF_BLOCK = 2'h2;
   localparam logic [2:0] QUEUE_SIZE = 3'h6;
   localparam logic [2:0] PF_MIN_FREE = 3'h2;

   // Requesters, highest priority first
   localparam int NSRC = 7;
   localparam int SRC_LOCK = 0;
   localparam int SRC_SPLIT = 1;
   localparam int SRC_COP2 = 2;
   localparam int SRC_HOLD = 3;
   localparam int SRC_COPROCESSOR_OPERAND_REQUEST = 4;
   localparam int SRC_EU = 5;
   localparam int SRC_PF = 6;

   typedef enum logic [4:0] {
      BS_IDLE = 5'h01, BS_TS = 5'h02, BS_TC = 5'h04, BS_TI = 5'h08, BS_TH = 5'h10
   } lbseq_bst_t;

   typedef enum logic [2:0] {
      K_MEM = 3'h0, K_IO = 3'h1, K_INTA1 = 3'h2, K_INTA2 = 3'h3, K_HALT = 3'h4, K_SHUT = 3'h5
   } lbseq_kind_t;

   typedef struct packed {
      lbseq_kind_t kind;
      logic [23:0] addr;
      logic write;
      logic word;
      logic lock;
      logic fetch;
   } lbseq_op_t;

   typedef struct packed {
      logic valid;
      logic [23:0] addr;
      logic write;
      logic word;
      logic lock;
   } lbseq_req_t;

   typedef struct packed {
      logic valid;
      logic mem;
      logic write;
      logic word;
      logic [23:0] addr;
   } lbseq_esc_t;

endpackage : lbseq_pkg

// [hdl/lbseq_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module lbseq_sync #(
   parameter int W = 13,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lbseq_sync_t;

   lbseq_sync_t s_q, s_d;

   // Two-stage chain; only stage two is visible
   always_comb begin
      s_d = s_q;
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.s2;

endmodule : lbseq_sync
`default_nettype wire

// [hdl/lbseq_arb.sv]
`timescale 1ns/1ps
`default_nettype none

module lbseq_arb (
   input wire logic [lbseq_pkg::NSRC-1:0] req,
   output logic [lbseq_pkg::NSRC-1:0] gnt
);
   // Lowest index wins
   function automatic logic [lbseq_pkg::NSRC-1:0] pick(input logic [lbseq_pkg::NSRC-1:0] r);
      logic [lbseq_pkg::NSRC-1:0] g;
      logic found;
      g = '0;
      found = 1'b0;
      for (int i = 0; i < lbseq_pkg::NSRC; i++) begin
         if (r[i] && !found) begin
            g[i] = 1'b1;
            found = 1'b1;
         end
      end
      return g;
   endfunction : pick

   assign gnt = pick(req);

endmodule : lbseq_arb
`default_nettype wire

// [hdl/lbseq_top.sv]
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module lbseq_top (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic HOLD,
   input wire logic MASKABLE_INTERRUPT_REQUEST,
   input wire logic NMI,
   input wire logic COPROCESSOR_OPERAND_REQUEST,
   input wire logic READY_N,
   input wire logic [7:0] DATA_I,
   input wire lbseq_pkg::lbseq_req_t EU_REQ,
   output logic EU_ACK,
   input wire lbseq_pkg::lbseq_esc_t COPROCESSOR_ESCAPE_INSTRUCTION,
   input wire logic HALT_INSTR,
   input wire logic MULTI_EXC,
   input wire logic COP_OVERRUN,
   input wire logic EU_SOON,
   input wire logic [1:0] QUEUE_TAKE,
   output logic [23:0] ADDR_O,
   output logic ADDR_OE,
   output logic [1:0] STATUS_N_O,
   output logic STATUS_OE,
   output logic MIO_O,
   output logic COD_O,
   output logic MC_OE,
   output logic BHE_N_O,
   output logic LOCK_N_O,
   output logic BL_OE,
   output logic BUS_GRANT_ACK,
   output logic [7:0] INT_VECTOR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);
   typedef struct packed {
      lbseq_pkg::lbseq_bst_t bst;
      lbseq_pkg::lbseq_op_t cur;
      logic first_tc;
      logic [1:0] gap;
      logic hold_after;
      logic interrupt_acknowledge_cycle_busy;
      logic [1:0] cool;
      logic halted;
      logic shutdown;
      logic per_inhibit;
      logic cop_armed;
      logic [23:0] cop_addr;
      logic cop_write;
      logic cop_word;
      logic cop_step;
      logic esc_pend;
      logic hlt_pend;
      logic shut_pend;
      logic split_pend;
      logic [23:0] split_addr;
      logic last_write;
      logic [2:0] queue;
      logic [23:0] pf_addr;
      logic [1:0] pf_block;
      logic [7:0] vector;
      logic [2:0] ctrl;
   } lbseq_state_t;

   lbseq_state_t s_q, s_d;
   logic [12:0] sync_q;
   logic hold_s, maskable_interrupt_request_s, nmi_s, coprocessor_operand_request_s, ready_n_s;
   logic [7:0] data_s;
   logic [lbseq_pkg::NSRC-1:0] req, gnt;
   logic eu_ok, interrupt_acknowledge_cycle_req, tc_done, ts, th, rel, eu_own, apb_wr;
   lbseq_pkg::lbseq_req_t iss;

   // Pin inputs through two flip-flops
   lbseq_sync #(.W(13), .RST_VAL(13'h0800)) u_sync (
      .clk(CLOCK),
      .rst_n(RST_N),
      .d({NMI, READY_N, HOLD, MASKABLE_INTERRUPT_REQUEST, COPROCESSOR_OPERAND_REQUEST, DATA_I}),
      .q(sync_q)
   );
   assign {nmi_s, ready_n_s, hold_s, maskable_interrupt_request_s, coprocessor_operand_request_s, data_s} = sync_q;

   // Request vector in priority order
   assign eu_ok = !s_q.halted && !s_q.shutdown && !s_q.hlt_pend && !s_q.shut_pend;
   assign interrupt_acknowledge_cycle_req = maskable_interrupt_request_s && s_q.ctrl[lbseq_pkg::CTRL_IE_BIT] && !s_q.interrupt_acknowledge_cycle_busy
                     && s_q.cool == 2'h0 && !s_q.shutdown;
   assign req[lbseq_pkg::SRC_LOCK] = interrupt_acknowledge_cycle_req || (EU_REQ.valid && EU_REQ.lock && eu_ok);
   assign req[lbseq_pkg::SRC_SPLIT] = s_q.split_pend;
   assign req[lbseq_pkg::SRC_COP2] = s_q.cop_step;
   assign req[lbseq_pkg::SRC_HOLD] = hold_s;
   assign req[lbseq_pkg::SRC_COPROCESSOR_OPERAND_REQUEST] = coprocessor_operand_request_s && s_q.cop_armed && !s_q.per_inhibit;
   assign req[lbseq_pkg::SRC_EU] = s_q.esc_pend || s_q.hlt_pend || s_q.shut_pend
                                   || (EU_REQ.valid && eu_ok);
   assign req[lbseq_pkg::SRC_PF] = (lbseq_pkg::QUEUE_SIZE - s_q.queue) >= lbseq_pkg::PF_MIN_FREE
                                   && s_q.pf_block == 2'h0 && !EU_REQ.valid && eu_ok;

   lbseq_arb u_arb (
      .req(req),
      .gnt(gnt)
   );

   // Phase decode of the bus engine
   assign ts = s_q.bst == lbseq_pkg::BS_TS;
   assign th = s_q.bst == lbseq_pkg::BS_TH;
   assign rel = s_q.bst == lbseq_pkg::BS_TI && s_q.hold_after;
   assign tc_done = s_q.bst == lbseq_pkg::BS_TC && (s_q.cur.kind == lbseq_pkg::K_HALT
                    || s_q.cur.kind == lbseq_pkg::K_SHUT || !ready_n_s);
   assign eu_own = !s_q.esc_pend && !s_q.hlt_pend && !s_q.shut_pend;
   assign EU_ACK = s_q.bst == lbseq_pkg::BS_IDLE && EU_REQ.valid
                   && ((gnt[lbseq_pkg::SRC_LOCK] && !interrupt_acknowledge_cycle_req) || (gnt[lbseq_pkg::SRC_EU] && eu_own));
   assign apb_wr = PSEL && PENABLE && PWRITE && PADDR == lbseq_pkg::REG_CTRL;

   // Next state of the sequencer
   always_comb begin
      s_d = s_q;
      iss = '0;
      if (s_q.pf_block != 2'h0) begin
         s_d.pf_block = s_q.pf_block - 2'h1;
      end
      if (EU_SOON) begin
         s_d.pf_block = lbseq_pkg::PF_BLOCK;
      end
      if (s_q.cool != 2'h0) begin
         s_d.cool = s_q.cool - 2'h1;
      end
      if (apb_wr) begin
         s_d.ctrl = PWDATA[2:0];
      end
      if (COPROCESSOR_ESCAPE_INSTRUCTION.valid && !s_q.ctrl[lbseq_pkg::CTRL_EM_BIT] && !s_q.ctrl[lbseq_pkg::CTRL_TS_BIT]) begin
         s_d.esc_pend = 1'b1;
         s_d.cop_armed = COPROCESSOR_ESCAPE_INSTRUCTION.mem;
         s_d.cop_addr = COPROCESSOR_ESCAPE_INSTRUCTION.addr;
         s_d.cop_write = COPROCESSOR_ESCAPE_INSTRUCTION.write;
         s_d.cop_word = COPROCESSOR_ESCAPE_INSTRUCTION.word;
      end
      if (HALT_INSTR) begin
         s_d.hlt_pend = 1'b1;
      end
      if (MULTI_EXC) begin
         s_d.shut_pend = 1'b1;
      end
      // Leaving halt or shutdown
      if (nmi_s) begin
         s_d.halted = 1'b0;
         s_d.shutdown = 1'b0;
      end
      if (s_q.halted && !s_q.shutdown && (COP_OVERRUN || interrupt_acknowledge_cycle_req)) begin
         s_d.halted = 1'b0;
      end
      if (s_q.shutdown && COP_OVERRUN) begin
         s_d.per_inhibit = 1'b1;
      end
      case (s_q.bst)
         lbseq_pkg::BS_IDLE: begin
            // Grant only between operations
            if (gnt[lbseq_pkg::SRC_LOCK] && interrupt_acknowledge_cycle_req) begin
               s_d.cur = '{lbseq_pkg::K_INTA1, 24'h0, 1'b0, 1'b1, 1'b1, 1'b0};
               s_d.interrupt_acknowledge_cycle_busy = 1'b1;
               s_d.bst = lbseq_pkg::BS_TS;
            end else if (gnt[lbseq_pkg::SRC_LOCK]) begin
               iss = EU_REQ;
            end else if (gnt[lbseq_pkg::SRC_SPLIT]) begin
               s_d.cur.addr = s_q.split_addr;
               s_d.cur.word = 1'b0;
               s_d.split_pend = 1'b0;
               s_d.bst = lbseq_pkg::BS_TS;
            end else if (gnt[lbseq_pkg::SRC_COP2]) begin
               iss = '{1'b1, s_q.cop_addr, s_q.cop_write, s_q.cop_word, 1'b0};
               s_d.cop_step = 1'b0;
               s_d.cop_addr = s_q.cop_addr + (s_q.cop_word ? 24'h2 : 24'h1);
            end else if (gnt[lbseq_pkg::SRC_HOLD]) begin
               s_d.bst = s_q.last_write ? lbseq_pkg::BS_TI : lbseq_pkg::BS_TH;
               s_d.hold_after = s_q.last_write;
            end else if (gnt[lbseq_pkg::SRC_COPROCESSOR_OPERAND_REQUEST]) begin
               s_d.cur = '{lbseq_pkg::K_IO, lbseq_pkg::COP_PORT_DATA, !s_q.cop_write, 1'b1, 1'b0, 1'b0};
               s_d.cop_step = 1'b1;
               s_d.bst = lbseq_pkg::BS_TS;
            end else if (gnt[lbseq_pkg::SRC_EU] && s_q.esc_pend) begin
               s_d.cur = '{lbseq_pkg::K_IO, lbseq_pkg::COP_PORT_CMD, 1'b1, 1'b1, 1'b0, 1'b0};
               s_d.esc_pend = 1'b0;
               s_d.bst = lbseq_pkg::BS_TS;
            end else if (gnt[lbseq_pkg::SRC_EU] && s_q.hlt_pend) begin
               s_d.cur = '{lbseq_pkg::K_HALT, lbseq_pkg::HALT_ADDR, 1'b0, 1'b1, 1'b0, 1'b0};
               s_d.bst = lbseq_pkg::BS_TS;
            end else if (gnt[lbseq_pkg::SRC_EU] && s_q.shut_pend) begin
               s_d.cur = '{lbseq_pkg::K_SHUT, lbseq_pkg::SHUT_ADDR, 1'b0, 1'b1, 1'b0, 1'b0};
               s_d.bst = lbseq_pkg::BS_TS;
            end else if (gnt[lbseq_pkg::SRC_EU]) begin
               iss = EU_REQ;
            end else if (gnt[lbseq_pkg::SRC_PF]) begin
               iss = '{1'b1, s_q.pf_addr, 1'b0, 1'b1, 1'b0};
            end
            // Memory operation, odd word split in two bytes
            if (iss.valid) begin
               s_d.cur = '{lbseq_pkg::K_MEM, iss.addr, iss.write, iss.word && !iss.addr[0], iss.lock,
                           gnt[lbseq_pkg::SRC_PF]};
               s_d.split_pend = iss.word && iss.addr[0];
               s_d.split_addr = iss.addr + 24'h1;
               s_d.bst = lbseq_pkg::BS_TS;
            end
         end
         lbseq_pkg::BS_TS: begin
            s_d.bst = lbseq_pkg::BS_TC;
            s_d.first_tc = 1'b1;
         end
         lbseq_pkg::BS_TC: begin
            s_d.first_tc = 1'b0;
            if (tc_done) begin
               s_d.last_write = s_q.cur.write;
               s_d.bst = lbseq_pkg::BS_IDLE;
               if (s_q.cur.kind == lbseq_pkg::K_INTA1) begin
                  s_d.bst = lbseq_pkg::BS_TI;
                  s_d.gap = lbseq_pkg::INTERRUPT_ACKNOWLEDGE_CYCLE_GAP;
               end else if (gnt[lbseq_pkg::SRC_HOLD]) begin
                  s_d.bst = s_q.cur.write ? lbseq_pkg::BS_TI : lbseq_pkg::BS_TH;
                  s_d.hold_after = s_q.cur.write;
               end
               if (s_q.cur.kind == lbseq_pkg::K_INTA2) begin
                  s_d.vector = data_s;
                  s_d.interrupt_acknowledge_cycle_busy = 1'b0;
                  s_d.cool = lbseq_pkg::INTERRUPT_ACKNOWLEDGE_CYCLE_COOL;
               end
               // A new halt or shutdown in the same cycle stays pending
               if (s_q.cur.kind == lbseq_pkg::K_HALT) begin
                  s_d.halted = 1'b1;
                  s_d.hlt_pend = HALT_INSTR;
               end
               if (s_q.cur.kind == lbseq_pkg::K_SHUT) begin
                  s_d.halted = 1'b1;
                  s_d.shutdown = 1'b1;
                  s_d.shut_pend = MULTI_EXC;
               end
               if (s_q.cur.fetch) begin
                  s_d.queue = s_q.queue + 3'h2;
                  s_d.pf_addr = s_q.pf_addr + 24'h2;
               end
            end
         end
         lbseq_pkg::BS_TI: begin
            if (s_q.hold_after) begin
               s_d.hold_after = 1'b0;
               s_d.bst = lbseq_pkg::BS_TH;
            end else if (s_q.gap == 2'h1) begin
               s_d.cur.kind = lbseq_pkg::K_INTA2;
               s_d.bst = lbseq_pkg::BS_TS;
            end else begin
               s_d.gap = s_q.gap - 2'h1;
            end
         end
         lbseq_pkg::BS_TH: begin
            if (!hold_s) begin
               s_d.bst = lbseq_pkg::BS_IDLE;
            end
         end
         default: begin
            s_d.bst = lbseq_pkg::BS_IDLE;
         end
      endcase
      // Queue drained by the decoder
      if ({1'b0, QUEUE_TAKE} > s_d.queue) begin
         s_d.queue = 3'h0;
      end else begin
         s_d.queue = s_d.queue - {1'b0, QUEUE_TAKE};
      end
      if (nmi_s) begin
         s_d.halted = 1'b0;
         s_d.shutdown = 1'b0;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         s_q <= '{bst: lbseq_pkg::BS_IDLE, cur: '{lbseq_pkg::K_MEM, 24'h0, 1'b0, 1'b0, 1'b0, 1'b0},
                  pf_addr: lbseq_pkg::PF_RESET_ADDR, ctrl: lbseq_pkg::CTRL_RESET, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Pin drive and float control
   always_comb begin
      ADDR_O = s_q.cur.addr;
      ADDR_OE = !(th || rel) && !(s_q.cur.kind == lbseq_pkg::K_INTA1 && s_q.bst != lbseq_pkg::BS_IDLE)
                && !(s_q.cur.kind == lbseq_pkg::K_INTA2 && (ts || s_q.first_tc));
      MC_OE = !(th || rel);
      BL_OE = !th;
      STATUS_OE = !th;
      STATUS_N_O = lbseq_pkg::CODE_IDLE;
      if (ts) begin
         case (s_q.cur.kind)
            lbseq_pkg::K_MEM, lbseq_pkg::K_IO: begin
               STATUS_N_O = s_q.cur.write ? lbseq_pkg::CODE_WRITE : lbseq_pkg::CODE_READ;
            end
            default: begin
               STATUS_N_O = lbseq_pkg::CODE_ACK;
            end
         endcase
      end
      MIO_O = s_q.cur.kind == lbseq_pkg::K_MEM || s_q.cur.kind == lbseq_pkg::K_HALT
              || s_q.cur.kind == lbseq_pkg::K_SHUT;
      COD_O = s_q.cur.fetch;
      BHE_N_O = !(s_q.cur.word || s_q.cur.addr[0]);
      LOCK_N_O = !(s_q.cur.lock && (ts || s_q.first_tc));
      BUS_GRANT_ACK = th;
      INT_VECTOR = s_q.vector;
   end

   // APB read side, zero wait states
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && PADDR != lbseq_pkg::REG_CTRL && PADDR != lbseq_pkg::REG_STAT;
   always_comb begin
      PRDATA = 32'h0;
      if (PADDR == lbseq_pkg::REG_CTRL) begin
         PRDATA[2:0] = s_q.ctrl;
      end else if (PADDR == lbseq_pkg::REG_STAT) begin
         PRDATA[4:0] = {s_q.cop_armed, th, s_q.per_inhibit, s_q.shutdown, s_q.halted};
         PRDATA[lbseq_pkg::STAT_QUEUE_LSB +: 3] = s_q.queue;
         PRDATA[lbseq_pkg::STAT_VEC_LSB +: 8] = s_q.vector;
      end
   end

   // Checks on the sequencer
   interrupt_acknowledge_cycle_gap_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (tc_done && s_q.cur.kind == lbseq_pkg::K_INTA1) |=>
      (s_q.bst == lbseq_pkg::BS_TI)[*3] ##1 (ts && s_q.cur.kind == lbseq_pkg::K_INTA2))
      else $error("acknowledge gap is not three idle clocks");
   hold_block_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N) s_q.interrupt_acknowledge_cycle_busy |-> !BUS_GRANT_ACK)
      else $error("hold granted inside acknowledge sequence");
   halt_code_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N) (ts && s_q.cur.kind == lbseq_pkg::K_HALT) |->
      (STATUS_N_O == 2'h0 && !COD_O && MIO_O && ADDR_O[1]))
      else $error("halt cycle badly encoded");
   shut_code_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N) (ts && s_q.cur.kind == lbseq_pkg::K_SHUT) |->
      (STATUS_N_O == 2'h0 && MIO_O && !ADDR_O[1]))
      else $error("shutdown cycle badly encoded");
   halt_noready_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (ts && (s_q.cur.kind == lbseq_pkg::K_HALT || s_q.cur.kind == lbseq_pkg::K_SHUT)) |=>
      (s_q.bst == lbseq_pkg::BS_TC) ##1 (s_q.bst != lbseq_pkg::BS_TC))
      else $error("halt cycle waited for ready");
   write_hold_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (tc_done && s_q.cur.write && gnt[lbseq_pkg::SRC_HOLD] && s_q.cur.kind != lbseq_pkg::K_INTA1) |=>
      (s_q.bst == lbseq_pkg::BS_TI && !BUS_GRANT_ACK) ##1 BUS_GRANT_ACK)
      else $error("write to hold grant is not one idle");
   lock_interrupt_acknowledge_cycle_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (ts && (s_q.cur.kind == lbseq_pkg::K_INTA1 || s_q.cur.kind == lbseq_pkg::K_INTA2)) |->
      !LOCK_N_O ##1 !LOCK_N_O ##1 LOCK_N_O)
      else $error("atomic flag wrong in acknowledge cycle");
   addr_float_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N) (ts && s_q.cur.kind == lbseq_pkg::K_INTA2) |->
      !ADDR_OE ##1 !ADDR_OE ##1 ADDR_OE)
      else $error("address float wrong in second acknowledge");
   status_hold_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N) BUS_GRANT_ACK |-> (!STATUS_OE && STATUS_N_O == 2'h3 && !ADDR_OE))
      else $error("status not floated high while granted");
   cop_port_a: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      (s_q.bst == lbseq_pkg::BS_IDLE && gnt[lbseq_pkg::SRC_COPROCESSOR_OPERAND_REQUEST]) |=>
      (ts && s_q.cur.kind == lbseq_pkg::K_IO && ADDR_O == 24'h0000fa))
      else $error("operand transfer missed the data port");

endmodule : lbseq_top
`default_nettype wire

// [test/lbseq_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none

module lbseq_bus_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] st_n,
   input wire logic mio,
   output logic rdy_n = 1'b1,
   output logic [7:0] dat = 8'h00
);
   int wq;
   logic busy = 1'b0;
   // Ends each operation except halt and shutdown after its waits; the vector rides the ready cycle
   always @(posedge clk) begin
      rdy_n <= 1'b1;
      dat <= ~dat;
      if (!rst_n) begin
         busy <= 1'b0;
      end else if (busy && wq == 0) begin
         busy <= 1'b0;
         rdy_n <= 1'b0;
         dat <= 8'h5a;
      end else if (busy) begin
         wq <= wq - 1;
      end else if (st_n != 2'h3 && !(st_n == 2'h0 && mio)) begin
         busy <= 1'b1;
         wq <= (st_n == 2'h0) ? 1 : 0;
      end
   end
endmodule : lbseq_bus_model

`default_nettype wire

// [test/lbseq_test.sv]
`timescale 1ns/1ps
`default_nettype none

module lbseq_test;
   logic CLOCK = 1'b0, RST_N = 1'b0, HOLD = 1'b0, MASKABLE_INTERRUPT_REQUEST = 1'b0, NMI = 1'b0, COPROCESSOR_OPERAND_REQUEST = 1'b0;
   logic HALT_INSTR = 1'b0, MULTI_EXC = 1'b0, COP_OVERRUN = 1'b0, EU_SOON = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [1:0] QUEUE_TAKE = 2'h0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h00000000;
   lbseq_pkg::lbseq_req_t EU_REQ = '0;
   lbseq_pkg::lbseq_esc_t COPROCESSOR_ESCAPE_INSTRUCTION = '0;
   logic READY_N, EU_ACK, ADDR_OE, STATUS_OE, MIO_O, COD_O, MC_OE, BHE_N_O, LOCK_N_O, BL_OE, BUS_GRANT_ACK;
   logic PREADY, PSLVERR, early, halt_a1;
   logic [7:0] DATA_I, INT_VECTOR;
   logic [23:0] ADDR_O;
   logic [1:0] STATUS_N_O;
   logic [31:0] PRDATA, rd;
   logic [24:0] ops[$];
   int err_total = 0, n_compared = 0, n_ack = 0, n_halt = 0, n_pf = 0, h0;

   lbseq_top u_lbseq_top (.CLOCK, .RST_N, .HOLD, .MASKABLE_INTERRUPT_REQUEST, .NMI, .COPROCESSOR_OPERAND_REQUEST, .READY_N, .DATA_I, .EU_REQ, .EU_ACK,
      .COPROCESSOR_ESCAPE_INSTRUCTION, .HALT_INSTR, .MULTI_EXC, .COP_OVERRUN, .EU_SOON, .QUEUE_TAKE, .ADDR_O, .ADDR_OE, .STATUS_N_O,
      .STATUS_OE, .MIO_O, .COD_O, .MC_OE, .BHE_N_O, .LOCK_N_O, .BL_OE, .BUS_GRANT_ACK, .INT_VECTOR, .PSEL, .PENABLE,
      .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
   lbseq_bus_model u_lbseq_bus_model (.clk(CLOCK), .rst_n(RST_N), .st_n(STATUS_N_O), .mio(MIO_O),
      .rdy_n(READY_N), .dat(DATA_I));

   // Clock
   always #20 CLOCK = ~CLOCK;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("compared %0d, wrong %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rd = PRDATA;
      early = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask : apb

   // Sorts each bus operation by its start status
   always @(posedge CLOCK) begin
      if (RST_N && STATUS_OE === 1'b1 && STATUS_N_O !== lbseq_pkg::CODE_IDLE) begin
         if (STATUS_N_O === lbseq_pkg::CODE_ACK && MIO_O === 1'b0) begin
            n_ack <= n_ack + 1;
            chk(LOCK_N_O, 1'b0);
            chk(ADDR_OE, 1'b0);
         end else if (STATUS_N_O === lbseq_pkg::CODE_ACK) begin
            n_halt <= n_halt + 1;
            halt_a1 <= ADDR_O[1];
            chk(COD_O, 1'b0);
         end else if (COD_O === 1'b1) n_pf <= n_pf + 1;
         else ops.push_back({MIO_O, ADDR_O});
      end
   end

   task automatic t_hold;
      HOLD <= 1'b1;
      while (BUS_GRANT_ACK !== 1'b1) @(posedge CLOCK);
      chk(STATUS_OE, 1'b0);
      chk({ADDR_OE, MC_OE, BL_OE}, 3'h0);
      HOLD <= 1'b0;
      while (BUS_GRANT_ACK !== 1'b0) @(posedge CLOCK);
      $display("hold done");
   endtask : t_hold

   task automatic t_copro;
      COPROCESSOR_OPERAND_REQUEST <= 1'b1;
      repeat (8) @(posedge CLOCK);
      COPROCESSOR_OPERAND_REQUEST <= 1'b0;
      repeat (4) @(posedge CLOCK);
      chk(ops.size(), 0);
      COPROCESSOR_ESCAPE_INSTRUCTION <= '{valid: 1'b1, mem: 1'b1, write: 1'b0, word: 1'b1, addr: 24'h001001};
      @(posedge CLOCK);
      COPROCESSOR_ESCAPE_INSTRUCTION.valid <= 1'b0;
      while (ops.size() < 1) @(posedge CLOCK);
      COPROCESSOR_OPERAND_REQUEST <= 1'b1;
      while (ops.size() < 2) @(posedge CLOCK);
      COPROCESSOR_OPERAND_REQUEST <= 1'b0;
      repeat (40) @(posedge CLOCK);
      chk(ops.size(), 4);
      chk(ops[0], {1'b0, lbseq_pkg::COP_PORT_CMD});
      chk(ops[1], {1'b0, lbseq_pkg::COP_PORT_DATA});
      chk(ops[2], 25'h1001001);
      chk(ops[3], 25'h1001002);
      ops.delete();
      $display("coprocessor done");
   endtask : t_copro

   task automatic t_eu;
      h0 = n_pf;
      EU_SOON <= 1'b1;
      QUEUE_TAKE <= 2'h2;
      @(posedge CLOCK);
      EU_SOON <= 1'b0;
      QUEUE_TAKE <= 2'h0;
      EU_REQ <= '{valid: 1'b1, addr: 24'h000203, write: 1'b1, word: 1'b1, lock: 1'b0};
      while (EU_ACK !== 1'b1) @(posedge CLOCK);
      EU_REQ.valid <= 1'b0;
      repeat (40) @(posedge CLOCK);
      chk(ops.size(), 2);
      chk(ops[0], 25'h1000203);
      chk(ops[1], 25'h1000204);
      chk(n_pf > h0, 1'b1);
      $display("data transfer done");
   endtask : t_eu

   task automatic t_interrupt_acknowledge_cycle;
      MASKABLE_INTERRUPT_REQUEST <= 1'b1;
      while (n_ack < 1) @(posedge CLOCK);
      MASKABLE_INTERRUPT_REQUEST <= 1'b0;
      HOLD <= 1'b1;
      early = 1'b0;
      while (INT_VECTOR !== 8'h5a) begin
         @(posedge CLOCK);
         if (BUS_GRANT_ACK === 1'b1 && INT_VECTOR !== 8'h5a) early = 1'b1;
      end
      chk(early, 1'b0);
      chk(n_ack, 2);
      HOLD <= 1'b0;
      repeat (20) @(posedge CLOCK);
      chk(n_ack, 2);
      $display("acknowledge done");
   endtask : t_interrupt_acknowledge_cycle

   task automatic t_halt;
      h0 = n_halt;
      HALT_INSTR <= 1'b1;
      @(posedge CLOCK);
      HALT_INSTR <= 1'b0;
      while (n_halt == h0) @(posedge CLOCK);
      chk(halt_a1, 1'b1);
      apb(1'b0, lbseq_pkg::REG_STAT, 32'h0);
      chk(rd[1:0], 2'h1);
      NMI <= 1'b1;
      repeat (4) @(posedge CLOCK);
      NMI <= 1'b0;
      h0 = n_halt;
      MULTI_EXC <= 1'b1;
      @(posedge CLOCK);
      MULTI_EXC <= 1'b0;
      while (n_halt == h0) @(posedge CLOCK);
      chk(halt_a1, 1'b0);
      COP_OVERRUN <= 1'b1;
      @(posedge CLOCK);
      COP_OVERRUN <= 1'b0;
      repeat (4) @(posedge CLOCK);
      apb(1'b0, lbseq_pkg::REG_STAT, 32'h0);
      chk(rd[2:0], 3'h7);
      t_hold();
      NMI <= 1'b1;
      repeat (4) @(posedge CLOCK);
      NMI <= 1'b0;
      apb(1'b0, lbseq_pkg::REG_STAT, 32'h0);
      chk(rd[1:0], 2'h0);
      $display("halt done");
   endtask : t_halt

   // Main sequence
   initial begin
      repeat (8) @(posedge CLOCK);
      RST_N <= 1'b1;
      apb(1'b0, lbseq_pkg::REG_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, lbseq_pkg::REG_CTRL, 32'h4);
      apb(1'b0, lbseq_pkg::REG_CTRL, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 12'h008, 32'h0);
      chk({early, rd}, 33'h100000000);
      t_copro();
      t_eu();
      t_interrupt_acknowledge_cycle();
      t_halt();
      results();
   end

   // Watchdog
   initial begin
      #200000;
      err_total++;
      results();
   end
endmodule : lbseq_test

`default_nettype wire
